/* verif/bcc_analog_model.sv */
// behavioural integrator and limit comparators facing the dac
`timescale 1ns/1ps
module bcc_analog_model
(
   input  wire logic              clk_i,
   input  wire logic [1:0]        force_i,
   input  wire logic signed [7:0] target_i,
   input  wire logic [8:0]        dac_code_i,
   input  wire logic              dac_sign_i,
   output logic                   comp_pos_o,
   output logic                   high_limit_o,
   output logic                   low_limit_o
);
   logic signed [10:0] level;
   // the loop settles where the dac matches the input; forcing pins it to a rail
   assign level = dac_sign_i ? -$signed({2'b00, dac_code_i}) : $signed({2'b00, dac_code_i});
   assign comp_pos_o = force_i[0] || (!force_i[1] && level < target_i);
   assign high_limit_o = force_i[0];
   assign low_limit_o = force_i[1];
endmodule : bcc_analog_model

/* verif/bcc_sva.sv */
// port assertions for the battery charge counter
`timescale 1ns/1ps
module bcc_sva
#(
   parameter int SAMPLE_DIV = 16
)
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 hsel_i,
   input wire logic [31:0]          haddr_i,
   input wire bcc_pkg::bcc_htrans_e htrans_i,
   input wire logic                 hwrite_i,
   input wire logic [31:0]          hwdata_i,
   input wire logic                 hready_i,
   input wire logic [31:0]          hrdata_o,
   input wire logic                 hreadyout_o,
   input wire logic                 hresp_o,
   input wire logic                 analog_enable_o,
   input wire logic                 chop_sign_o,
   input wire logic [2:0]           current_segment_o,
   input wire logic [8:0]           dac_code_o,
   input wire logic                 dac_sign_o,
   input wire logic [1:0]           limit_threshold_select_o
);
   import bcc_pkg::*;
   // overrides reach the outputs without waiting for a sample strobe
   localparam int OVR_WAIT = SAMPLE_DIV + 4;
   logic tk;
   assign tk = hsel_i && hready_i && (htrans_i inside {BCC_HT_NONSEQ, BCC_HT_SEQ});
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_lim;
      logic [1:0] d;
      (tk && hwrite_i && haddr_i[8:2] == 7'h44) ##1 (1'b1, d = hwdata_i[1:0])
         |-> ##[1:2] limit_threshold_select_o == d;
   endproperty
   property p_ena;
      logic e;
      (tk && hwrite_i && haddr_i[8:2] == 7'h40) ##1 (1'b1, e = hwdata_i[0])
         |-> ##[1:3] analog_enable_o == e;
   endproperty
   property p_dac;
      logic [9:0] d;
      (tk && hwrite_i && haddr_i[8:2] == 7'h54) ##1 (hwdata_i[15], d = hwdata_i[9:0])
         |-> ##[1:OVR_WAIT] {dac_sign_o, dac_code_o} == d;
   endproperty
   property p_seg;
      logic [2:0] s;
      (tk && hwrite_i && haddr_i[8:2] == 7'h54) ##1 (hwdata_i[14], s = hwdata_i[13:11])
         |-> ##[1:OVR_WAIT] current_segment_o == s;
   endproperty
   a_ready_always: assert property (hreadyout_o)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (!hresp_o)
      else $error("slave answered with an error");
   a_reset_state: assert property ($fell(rst_i) |-> limit_threshold_select_o == 2'h1
      && !analog_enable_o && !chop_sign_o && dac_code_o == 9'h0 && hrdata_o == 32'h0)
      else $error("outputs not at reset state");
   a_lim_write: assert property (p_lim)
      else $error("limit select did not follow write");
   a_ena_write: assert property (p_ena)
      else $error("enable did not follow write");
   a_dac_override: assert property (p_dac)
      else $error("dac did not follow override");
   a_seg_override: assert property (p_seg)
      else $error("segment did not follow override");
   a_unmapped_zero: assert property (tk && !hwrite_i && haddr_i[8:2] == 7'h56 |=> hrdata_o == 0)
      else $error("unmapped read not zero");
   a_sum_hi_width: assert property (tk && !hwrite_i && haddr_i[8:2] == 7'h4c
      |=> hrdata_o[31:8] == 24'h0)
      else $error("sum high word too wide");
   a_status_width: assert property (tk && !hwrite_i && haddr_i[8:2] == 7'h52
      |=> hrdata_o[31:2] == 30'h0)
      else $error("status word too wide");
   c_status_read: cover property (tk && !hwrite_i && haddr_i[8:2] == 7'h52);
   c_chop_toggle: cover property ($changed(chop_sign_o));
   c_dac_full: cover property (dac_code_o == 9'd63);
endmodule : bcc_sva
bind bcc_top bcc_sva #(.SAMPLE_DIV(SAMPLE_DIV)) bcc_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .analog_enable_o(analog_enable_o), .chop_sign_o(chop_sign_o),
   .current_segment_o(current_segment_o), .dac_code_o(dac_code_o), .dac_sign_o(dac_sign_o),
   .limit_threshold_select_o(limit_threshold_select_o));

/* verif/bcc_top_tb.sv */
// self-checking bench for the battery charge counter
`timescale 1ns/1ps
`include "bcc_defs.svh"
module bcc_top_tb;
   import bcc_pkg::*;
   localparam int SDIV = 16;
   typedef struct {logic [31:0] ev; logic [31:0] mk;} bcc_note_s;
   logic clk_i, rst_i, hwrite_i, comp_pos_i, high_limit_i, low_limit_i, hreadyout_o, hresp_o;
   logic analog_enable_o, chop_sign_o, dac_sign_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rq, e;
   logic [2:0] current_segment_o, divider_segment_o;
   logic [8:0] dac_code_o;
   logic [1:0] limit_threshold_select_o, force_lim;
   logic signed [7:0] target;
   logic [7:0] lf;
   bcc_htrans_e htrans_i;
   bcc_note_s notes[$];
   bcc_note_s nt;
   logic dp_rd = 1'b0;
   int fails = 0;
   int n_tests = 0;
   logic [31:0] zro[6] = '{`BCC_OFF_EXTRA, `BCC_OFF_SUM_LO, `BCC_OFF_SUM_MID,
                          `BCC_OFF_SUM_HI, `BCC_OFF_AVG, `BCC_OFF_EXT};
   bcc_top #(.SAMPLE_DIV(SDIV)) bcc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .comp_pos_i(comp_pos_i),
      .high_limit_i(high_limit_i), .low_limit_i(low_limit_i),
      .analog_enable_o(analog_enable_o), .chop_sign_o(chop_sign_o),
      .current_segment_o(current_segment_o), .divider_segment_o(divider_segment_o),
      .dac_code_o(dac_code_o), .dac_sign_o(dac_sign_o),
      .limit_threshold_select_o(limit_threshold_select_o));
   bcc_analog_model bcc_analog_model_inst (.clk_i(clk_i), .force_i(force_lim),
      .target_i(target), .dac_code_i(dac_code_o), .dac_sign_i(dac_sign_o),
      .comp_pos_o(comp_pos_i), .high_limit_o(high_limit_i), .low_limit_o(low_limit_i));
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   // printed offsets are word indices
   function automatic logic [31:0] ba(input logic [31:0] off);
      return {23'h0, off[6:0], 2'b00};
   endfunction : ba
   function automatic logic [15:0] cb(input int w, input int ch, input int dc, input int sc);
      return {1'b0, w[2:0], 1'b0, ch[2:0], 2'b00, dc[0], sc[2:0], 2'b10};
   endfunction : cb
   function automatic logic [2:0] sig(input int sel);
      return sel == 0 ? current_segment_o : sel == 1 ? divider_segment_o : {2'b00, chop_sign_o};
   endfunction : sig
   task test_done();
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         fails++;
         $display("[FAIL] %s exp %h got %h", nm, ex, got);
      end
   endtask : chk
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int g;
      g = 0;
      @(posedge clk_i);
      htrans_i <= BCC_HT_NONSEQ;
      haddr_i  <= a;
      hwrite_i <= w;
      do begin @(posedge clk_i); g++; end while (hreadyout_o !== 1'b1 && g < 50);
      htrans_i <= BCC_HT_IDLE;
      hwdata_i <= d;
      do begin @(posedge clk_i); g++; end while (hreadyout_o !== 1'b1 && g < 100);
      rq = hrdata_o;
      if (g >= 100)
      begin
         fails++;
         test_done();
      end
   endtask : bus
   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [31:0] a, input logic [31:0] ex, input logic [31:0] mk);
      notes.push_back('{ex, mk});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task per(input int sel, input int ex);
      int c;
      logic [2:0] v;
      for (int k = 0; k < 2; k++)
      begin
         v = sig(sel);
         c = 0;
         do begin @(negedge clk_i); c++; end while (sig(sel) === v && c < 600);
      end
      chk("period", ex == 0 ? 600 : ex, c);
   endtask : per
   task strobes(input int n);
      repeat (n * SDIV) @(posedge clk_i);
   endtask : strobes
   // read data is compared at the edge that ends its data phase
   always @(posedge clk_i)
   begin
      if (dp_rd && hreadyout_o === 1'b1 && notes.size() > 0)
      begin
         nt = notes.pop_front();
         if (nt.mk != 0)
            chk("read", nt.ev, hrdata_o & nt.mk);
      end
      dp_rd <= !rst_i && hreadyout_o && htrans_i == BCC_HT_NONSEQ && !hwrite_i;
   end
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (100000) @(posedge clk_i);
      fails++;
      test_done();
   end
   initial
   begin
      rst_i = 1'b1;
      htrans_i = BCC_HT_IDLE;
      haddr_i = 32'h0;
      hwrite_i = 1'b0;
      hwdata_i = 32'h0;
      force_lim = 2'h0;
      target = 8'sh0;
      lf = 8'd98;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ba(`BCC_OFF_CTRL_B), 32'h776a, '1);
      rd(ba(`BCC_OFF_CTRL_C), 32'h0011, '1);
      for (int i = 0; i < 6; i++)
         rd(ba(zro[i]), 32'h0, '1);
      rd(ba(`BCC_OFF_STATUS), 32'h0, '1);
      wr(ba(`BCC_OFF_CTRL_C), 32'hffee);
      rd(ba(`BCC_OFF_CTRL_C), 32'h002e, '1);
      chk("limit_sel", 2'h2, limit_threshold_select_o);
      wr(32'h158, '1);
      rd(32'h158, 32'h0, '1);
      wr(ba(`BCC_OFF_EXT), 32'heb55);
      strobes(2);
      chk("dac", 32'h355, {dac_sign_o, dac_code_o});
      chk("segment", 32'h5, current_segment_o);
      wr(ba(`BCC_OFF_EXT), 32'h0);
      for (int n = 1; n < 8; n++)
      begin
         wr(ba(`BCC_OFF_CTRL_B), cb(7, 7, 1, n));
         per(0, n * SDIV);
         per(1, n * SDIV);
      end
      wr(ba(`BCC_OFF_CTRL_B), cb(7, 7, 0, 3));
      per(1, 0);
      wr(ba(`BCC_OFF_CTRL_B), cb(7, 7, 1, 0));
      per(0, 0);
      for (int n = 1; n < 4; n++)
      begin
         wr(ba(`BCC_OFF_CTRL_B), cb(7, n, 1, 1));
         per(2, (1 << n) * SDIV);
      end
      wr(ba(`BCC_OFF_CTRL_B), 32'h8000 | cb(7, 0, 1, 1));
      for (int s = 1; s >= 0; s--)
      begin
         wr(ba(`BCC_OFF_CTRL_A), s << 5);
         strobes(1);
         chk("chop", s, chop_sign_o);
      end
      repeat (3) lf = lfsr(lf);
      e = {24'h0, lf} | 32'h1;
      wr(ba(`BCC_OFF_EXTRA), e);
      wr(ba(`BCC_OFF_CTRL_A), 32'h2);
      force_lim <= 2'h1;
      strobes(30);
      rd(ba(`BCC_OFF_SUM_LO), 32'h0, 32'h0);
      chk("sum_lo", 1, rq != 0 && rq % e == 0);
      rd(ba(`BCC_OFF_SUM_MID), 32'h0, '1);
      rd(ba(`BCC_OFF_AVG), 32'h0, 32'h0);
      chk("avg", 1, rq == e || rq == e - 1);
      force_lim <= 2'h0;
      wr(ba(`BCC_OFF_EXTRA), 32'hffc0);
      wr(ba(`BCC_OFF_CTRL_A), 32'h2);
      strobes(5);
      rd(ba(`BCC_OFF_SUM_HI), 32'h00ff, '1);
      rd(ba(`BCC_OFF_SUM_MID), 32'hffff, '1);
      wr(ba(`BCC_OFF_EXTRA), 32'h0);
      wr(ba(`BCC_OFF_CTRL_A), 32'h2);
      rd(ba(`BCC_OFF_SUM_LO), 32'h0, '1);
      rd(ba(`BCC_OFF_SUM_HI), 32'h0, '1);
      lf = lfsr(lf);
      target <= {3'b000, lf[4:0]};
      wr(ba(`BCC_OFF_CTRL_A), 32'h1);
      strobes(40);
      for (int d = 0; d < 2; d++)
      begin
         force_lim <= 2'(1 << d);
         strobes(3);
         rd(ba(`BCC_OFF_STATUS), 32'h2, '1);
         strobes(130);
         rd(ba(`BCC_OFF_STATUS), 32'h3, '1);
         force_lim <= 2'h0;
         strobes(8);
         rd(ba(`BCC_OFF_STATUS), 32'h0, '1);
      end
      test_done();
   end
endmodule : bcc_top_tb

/* verilog/bcc_defs.svh */
// constants for the battery charge counter: offsets, fields, reset values, timing
// How it works
// - chop field N in 1..7 toggles chopper sign every 2^N segment periods; resets 7
// - chop field 0 takes chopper sign from the software sign bit
// - current segments rotate every N samples for segment field N; 0 clears to segment 0; resets 2
// - divider-rotate bit set rotates divider segments once per segment period; resets 1
// - signed 16-bit extra charge (10.6 format) is added every sample period
// - per-sample charge summed into a 40-bit sum, read as three words, low first
// - full-scale charge is 6 bits; sum survives 2^26 full-scale periods
// - read-only signed 16-bit averaged charge, 10.6 format
// - locked flag sets whenever either limit comparator fires
// - locked flag clears after more than 2 periods with charge change under two steps
// - overload sets after more than 3 limit periods at full-scale DAC
// - DAC override bit drives DAC from software value, not the loop
// - segment override bit uses software segment number, not the rotation
// - 2-bit limit threshold select, resets to 1
// - dynamic hysteresis and dynamic target bits are storage only
// - average = (w*avg + q)/(w+1), w = 2^weight field, field resets 7
// - dynamic averaging forces weight 1 on big change or limit hit
// - average reset loads last sum; counter reset clears the sum
// - enable 0 turns converter off, extra charge still accumulates
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH
`define BCC_OFF_CTRL_A      32'h50001b40
`define BCC_OFF_CTRL_B      32'h50001b42
`define BCC_OFF_CTRL_C      32'h50001b44
`define BCC_OFF_EXTRA       32'h50001b46
`define BCC_OFF_SUM_LO      32'h50001b48
`define BCC_OFF_SUM_MID     32'h50001b4a
`define BCC_OFF_SUM_HI      32'h50001b4c
`define BCC_OFF_AVG         32'h50001b50
`define BCC_OFF_STATUS      32'h50001b52
`define BCC_OFF_EXT         32'h50001b54
`define BCC_CA_ENABLE       0
`define BCC_CA_RST_SUM      1
`define BCC_CA_RST_AVG      2
`define BCC_CA_SIGN         5
`define BCC_CB_DYNAVG       15
`define BCC_CB_WEIGHT_LSB   12
`define BCC_CB_CHOP_LSB     8
`define BCC_CB_DCYCLE       5
`define BCC_CB_SCYCLE_LSB   2
`define BCC_CC_LIMIT_LSB    0
`define BCC_EX_DAC_OVR      15
`define BCC_EX_SEG_OVR      14
`define BCC_EX_SEG_LSB      11
`define BCC_EX_DAC_SIGN     9
`define BCC_RST_CTRL_A      16'h0000
`define BCC_RST_CTRL_B      16'h776a
`define BCC_RST_CTRL_C      16'h0011
`define BCC_RST_EXT         16'h0000
`define BCC_CTRL_C_MASK     16'h003f
`define BCC_CLK_HZ          250000000
`define BCC_SAMPLE_HZ       144000
`define BCC_SAMPLE_CYC      (`BCC_CLK_HZ / `BCC_SAMPLE_HZ)
`define BCC_DAC_FULL        7'sd63
`define BCC_STEP            17'sd64
`define BCC_LOCK_SAFE       2
`define BCC_OVL_LIMIT       3
`endif

/* verilog/bcc_pkg.sv */
// types shared by the battery charge counter
package bcc_pkg;
   typedef logic signed [15:0] bcc_charge_t;
   typedef logic signed [39:0] bcc_sum_t;
   typedef logic signed [6:0]  bcc_dac_t;
   typedef logic        [15:0] bcc_word_t;
   typedef enum logic [1:0]
   {
      BCC_HT_IDLE   = 2'b00,
      BCC_HT_BUSY   = 2'b01,
      BCC_HT_NONSEQ = 2'b10,
      BCC_HT_SEQ    = 2'b11
   } bcc_htrans_e;
endpackage : bcc_pkg

/* verilog/bcc_top.sv */
// battery charge counter: register slave, loop control, accumulator, average, flags
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "bcc_defs.svh"
module bcc_top #(
   parameter int SAMPLE_DIV = `BCC_SAMPLE_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                hsel_i,
   input  wire logic [31:0]         haddr_i,
   input  wire bcc_pkg::bcc_htrans_e htrans_i,
   input  wire logic                hwrite_i,
   input  wire logic [2:0]          hsize_i,
   input  wire logic [31:0]         hwdata_i,
   input  wire logic                hready_i,
   output logic      [31:0]         hrdata_o,
   output logic                     hreadyout_o,
   output logic                     hresp_o,
   input  wire logic                comp_pos_i,
   input  wire logic                high_limit_i,
   input  wire logic                low_limit_i,
   output logic                     analog_enable_o,
   output logic                     chop_sign_o,
   output logic      [2:0]          current_segment_o,
   output logic      [2:0]          divider_segment_o,
   output logic      [8:0]          dac_code_o,
   output logic                     dac_sign_o,
   output logic      [1:0]          limit_threshold_select_o
);
   import bcc_pkg::*;

   if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535)
   begin : g_bad_div
      $error("SAMPLE_DIV out of range");
   end

   // printed offsets are register indices; the bus address is four times the index
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
      hit = (addr[8:2] == off[6:0]);
   endfunction : hit

   // bus slave
   logic        wr_pend_ff;
   logic [31:0] wr_addr_ff;
   logic        acc_ok;
   logic        wr_now;

   // registers
   bcc_word_t   ctrl_a_ff;
   bcc_word_t   ctrl_b_ff;
   bcc_word_t   ctrl_c_ff;
   bcc_charge_t extra_ff;
   bcc_word_t   ext_ff;
   logic        rst_sum_pulse;
   logic        rst_avg_pulse;

   // converter state
   logic [15:0] smp_cnt_ff;
   logic        smp_stb_ff;
   bcc_dac_t    dac_ff;
   bcc_charge_t charge_prev_ff;
   bcc_sum_t    sum_ff;
   bcc_charge_t avg_ff;
   logic        locked_ff;
   logic        overload_ff;
   logic [1:0]  safe_cnt_ff;
   logic [2:0]  ovl_cnt_ff;
   logic [2:0]  seg_cnt_ff;
   logic [2:0]  seg_ff;
   logic [2:0]  div_seg_ff;
   logic [9:0]  chop_cnt_ff;
   logic        chop_ff;

   logic        enable;
   logic [2:0]  chop_n;
   logic [2:0]  scycle;
   logic [2:0]  weight_n;
   logic        limit_hit;
   logic        dac_full;
   bcc_charge_t charge_now;
   logic signed [16:0] dcharge;
   logic [16:0] dcharge_abs;
   logic        seg_tick;
   logic [9:0]  chop_period;

   assign enable   = ctrl_a_ff[`BCC_CA_ENABLE];
   assign chop_n   = ctrl_b_ff[`BCC_CB_CHOP_LSB +: 3];
   assign scycle   = ctrl_b_ff[`BCC_CB_SCYCLE_LSB +: 3];
   assign weight_n = ctrl_b_ff[`BCC_CB_WEIGHT_LSB +: 3];
   assign limit_hit = high_limit_i | low_limit_i;
   assign dac_full  = (dac_ff == `BCC_DAC_FULL) || (dac_ff == -`BCC_DAC_FULL);

   // ---------------- AHB-Lite slave: zero wait states, always OKAY
   assign acc_ok = hsel_i && hready_i && htrans_i[1];
   assign wr_now = wr_pend_ff;
   assign rst_sum_pulse = wr_now && hit(wr_addr_ff, `BCC_OFF_CTRL_A)
                          && hwdata_i[`BCC_CA_RST_SUM];
   assign rst_avg_pulse = wr_now && hit(wr_addr_ff, `BCC_OFF_CTRL_A)
                          && hwdata_i[`BCC_CA_RST_AVG];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
      else
      begin
         wr_pend_ff  <= acc_ok && hwrite_i;
         wr_addr_ff  <= haddr_i;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // read data is captured in the address phase; a read right after a write
   // to the same word returns the value from before that write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hrdata_o <= 32'h0;
      end
      else if (acc_ok && !hwrite_i)
      begin
         if (hit(haddr_i, `BCC_OFF_CTRL_A))
            hrdata_o <= {16'h0, ctrl_a_ff};
         else if (hit(haddr_i, `BCC_OFF_CTRL_B))
            hrdata_o <= {16'h0, ctrl_b_ff};
         else if (hit(haddr_i, `BCC_OFF_CTRL_C))
            hrdata_o <= {16'h0, ctrl_c_ff};
         else if (hit(haddr_i, `BCC_OFF_EXTRA))
            hrdata_o <= {16'h0, extra_ff};
         else if (hit(haddr_i, `BCC_OFF_SUM_LO))
            hrdata_o <= {16'h0, sum_ff[15:0]};
         else if (hit(haddr_i, `BCC_OFF_SUM_MID))
            hrdata_o <= {16'h0, sum_ff[31:16]};
         else if (hit(haddr_i, `BCC_OFF_SUM_HI))
            hrdata_o <= {24'h0, sum_ff[39:32]};
         else if (hit(haddr_i, `BCC_OFF_AVG))
            hrdata_o <= {16'h0, avg_ff};
         else if (hit(haddr_i, `BCC_OFF_STATUS))
            hrdata_o <= {30'h0, locked_ff, overload_ff};
         else if (hit(haddr_i, `BCC_OFF_EXT))
            hrdata_o <= {16'h0, ext_ff};
         else
            hrdata_o <= 32'h0;
      end
   end

   // reset controls are write actions and read back as zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_a_ff <= `BCC_RST_CTRL_A;
         ctrl_b_ff <= `BCC_RST_CTRL_B;
         ctrl_c_ff <= `BCC_RST_CTRL_C;
         extra_ff  <= 16'h0;
         ext_ff    <= `BCC_RST_EXT;
      end
      else if (wr_now)
      begin
         if (hit(wr_addr_ff, `BCC_OFF_CTRL_A))
         begin
            ctrl_a_ff <= hwdata_i[15:0];
            ctrl_a_ff[`BCC_CA_RST_SUM] <= 1'b0;
            ctrl_a_ff[`BCC_CA_RST_AVG] <= 1'b0;
         end
         if (hit(wr_addr_ff, `BCC_OFF_CTRL_B))
            ctrl_b_ff <= hwdata_i[15:0];
         if (hit(wr_addr_ff, `BCC_OFF_CTRL_C))
            ctrl_c_ff <= hwdata_i[15:0] & `BCC_CTRL_C_MASK;
         if (hit(wr_addr_ff, `BCC_OFF_EXTRA))
            extra_ff <= hwdata_i[15:0];
         if (hit(wr_addr_ff, `BCC_OFF_EXT))
            ext_ff <= hwdata_i[15:0];
      end
   end

   // ---------------- sample strobe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         smp_cnt_ff <= 16'h0;
         smp_stb_ff <= 1'b0;
      end
      else if (smp_cnt_ff == 16'(SAMPLE_DIV - 1))
      begin
         smp_cnt_ff <= 16'h0;
         smp_stb_ff <= 1'b1;
      end
      else
      begin
         smp_cnt_ff <= smp_cnt_ff + 16'h1;
         smp_stb_ff <= 1'b0;
      end
   end

   // ---------------- loop controller: steps the DAC toward the comparator
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !enable)
         dac_ff <= 7'sd0;
      else if (smp_stb_ff)
      begin
         if (comp_pos_i && dac_ff != `BCC_DAC_FULL)
            dac_ff <= dac_ff + 7'sd1;
         else if (!comp_pos_i && dac_ff != -`BCC_DAC_FULL)
            dac_ff <= dac_ff - 7'sd1;
      end
   end

   // per-sample charge in 10.6 format, zero while the converter is off
   assign charge_now  = enable ? {{3{dac_ff[6]}}, dac_ff, 6'h0} : 16'sh0;
   assign dcharge     = 17'(charge_now) - 17'(charge_prev_ff);
   assign dcharge_abs = dcharge[16] ? 17'(-dcharge) : 17'(dcharge);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         charge_prev_ff <= 16'sh0;
      else if (smp_stb_ff)
         charge_prev_ff <= charge_now;
   end

   // ---------------- accumulator; counter reset wins over a same-cycle sample
   always_ff @(posedge clk_i)
   begin
      if (rst_i || rst_sum_pulse)
         sum_ff <= 40'sh0;
      else if (smp_stb_ff)
         sum_ff <= sum_ff + 40'(charge_now) + 40'(extra_ff);
   end

   // ---------------- moving average
   logic [2:0]         eff_w;
   logic signed [25:0] avg_num;
   logic signed [25:0] avg_den;
   logic signed [25:0] avg_q;

   always_comb
   begin
      eff_w = weight_n;
      if (ctrl_b_ff[`BCC_CB_DYNAVG]
          && (dcharge_abs > 17'(4 * `BCC_STEP) || limit_hit))
         eff_w = 3'h0;
      // the new charge is what the sum receives: converter charge plus extra charge
      avg_num = (26'(avg_ff) <<< eff_w) + 26'(charge_now) + 26'(extra_ff);
      avg_den = (26'sd1 <<< eff_w) + 26'sd1;
      avg_q   = avg_num / avg_den;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         avg_ff <= 16'sh0;
      else if (rst_avg_pulse)
         avg_ff <= sum_ff[15:0];
      else if (smp_stb_ff)
         avg_ff <= avg_q[15:0];
   end

   // ---------------- integrator flags; a limit hit outranks the safe-run clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         locked_ff   <= 1'b0;
         safe_cnt_ff <= 2'h0;
      end
      else if (smp_stb_ff)
      begin
         if (limit_hit)
         begin
            locked_ff   <= 1'b1;
            safe_cnt_ff <= 2'h0;
         end
         else if (dcharge_abs < 17'(2 * `BCC_STEP))
         begin
            if (safe_cnt_ff == 2'(`BCC_LOCK_SAFE))
               locked_ff <= 1'b0;
            else
               safe_cnt_ff <= safe_cnt_ff + 2'h1;
         end
         else
            safe_cnt_ff <= 2'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         overload_ff <= 1'b0;
         ovl_cnt_ff  <= 3'h0;
      end
      else if (smp_stb_ff)
      begin
         if (limit_hit && dac_full)
         begin
            if (ovl_cnt_ff == 3'(`BCC_OVL_LIMIT))
               overload_ff <= 1'b1;
            else
               ovl_cnt_ff <= ovl_cnt_ff + 3'h1;
         end
         else
         begin
            overload_ff <= 1'b0;
            ovl_cnt_ff  <= 3'h0;
         end
      end
   end

   // ---------------- segment rotation and chopping
   assign seg_tick    = smp_stb_ff && scycle != 3'h0 && seg_cnt_ff == scycle - 3'h1;
   // one chop period is 2^N segment periods, counted in segment ticks
   assign chop_period = 10'h1 << chop_n;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || scycle == 3'h0)
      begin
         seg_cnt_ff <= 3'h0;
         seg_ff     <= 3'h0;
      end
      else if (smp_stb_ff)
      begin
         if (seg_tick)
         begin
            seg_cnt_ff <= 3'h0;
            seg_ff     <= seg_ff + 3'h1;
         end
         else
            seg_cnt_ff <= seg_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         div_seg_ff <= 3'h0;
      else if (seg_tick && ctrl_b_ff[`BCC_CB_DCYCLE])
         div_seg_ff <= div_seg_ff + 3'h1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chop_cnt_ff <= 10'h0;
         chop_ff     <= 1'b0;
      end
      else if (chop_n == 3'h0)
      begin
         chop_cnt_ff <= 10'h0;
         chop_ff     <= ctrl_a_ff[`BCC_CA_SIGN];
      end
      else if (seg_tick)
      begin
         if (chop_cnt_ff >= chop_period - 10'h1)
         begin
            chop_cnt_ff <= 10'h0;
            chop_ff     <= ~chop_ff;
         end
         else
            chop_cnt_ff <= chop_cnt_ff + 10'h1;
      end
   end

   // ---------------- analog-facing outputs, all registered
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         analog_enable_o          <= 1'b0;
         chop_sign_o              <= 1'b0;
         current_segment_o        <= 3'h0;
         divider_segment_o        <= 3'h0;
         dac_code_o               <= 9'h0;
         dac_sign_o               <= 1'b0;
         limit_threshold_select_o <= 2'h1;
      end
      else
      begin
         analog_enable_o          <= enable;
         chop_sign_o              <= chop_ff;
         divider_segment_o        <= div_seg_ff;
         limit_threshold_select_o <= ctrl_c_ff[`BCC_CC_LIMIT_LSB +: 2];
         if (ext_ff[`BCC_EX_SEG_OVR])
            current_segment_o <= ext_ff[`BCC_EX_SEG_LSB +: 3];
         else
            current_segment_o <= seg_ff;
         if (ext_ff[`BCC_EX_DAC_OVR])
         begin
            dac_code_o <= ext_ff[8:0];
            dac_sign_o <= ext_ff[`BCC_EX_DAC_SIGN];
         end
         else
         begin
            dac_code_o <= {3'h0, (dac_ff[6] ? 6'(-dac_ff) : dac_ff[5:0])};
            dac_sign_o <= dac_ff[6];
         end
      end
   end

endmodule : bcc_top
